/* File: verilog/asp_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Selected: sample input on clock rise.
// - Selected: shift output on clock fall.
// - Deselected: ignore clock and input entirely.
// - Deselected: release serial output to high-impedance.
// - Internal timing: ready strobe rises on result.
// - External timing: ready strobe held low.
// - Ready strobe always driven, regardless of select.
// - First one after select starts configuration byte; a byte cut off by deselect resumes instead.
module asp_serial_port
    import asp_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_CS_N,
    input wire logic I_SCLK,
    input wire logic I_DIN,
    input wire logic I_INT_CLK_MODE,
    input wire logic I_RESULT_VALID,
    input wire logic [15:0] I_RESULT,
    output logic O_DOUT,
    output logic O_DOUT_OE,
    output logic O_RESULT_READY_STROBE,
    output logic O_CFG_VALID,
    output logic [7:0] O_CFG_BYTE
);
    // Every register of the port outside the pin synchroniser lives in this one
    // record, so that reset and update each stay in one place.
    typedef struct packed {
        asp_core_t core;
        logic [1:0] mode_sync;
        logic [1:0] res_sync;
        logic [15:0] result_hold;
    } asp_port_state_t;

    asp_pins_t pins;
    asp_port_state_t st_reg;
    asp_port_state_t st_next;
    logic int_timing;
    logic result_seen;

    // A one on the input at a detected rise opens a configuration byte.
    function automatic logic start_bit_seen(input asp_pins_t p);
        return p.sclk_rise & p.din;
    endfunction

    // The start bit already counts as the first of the eight bits.
    function automatic asp_core_t open_byte(input asp_core_t c);
        asp_core_t r;
        r = c;
        r.state = ASP_CFG;
        r.cfg_shift = {7'h00, 1'b1};
        r.cfg_count = 3'h1;
        return r;
    endfunction

    // Takes one bit into the byte; the eighth bit hands the byte over and
    // loads the held result for the data phase.
    function automatic asp_core_t take_bit(input asp_core_t c, input logic d,
                                          input logic [15:0] result);
        asp_core_t r;
        r = c;
        r.cfg_shift = {c.cfg_shift[6:0], d};
        r.cfg_count = c.cfg_count + 3'h1;
        if (c.cfg_count == 3'(START_BIT_POS)) begin
            r.cfg_valid = 1'b1;
            r.cfg_word = {c.cfg_shift[6:0], d};
            r.out_shift = result;
            r.state = ASP_DATA;
        end
        return r;
    endfunction

    // Puts the next result bit on the line, most significant first; zeros
    // follow once all sixteen bits are out.
    function automatic asp_core_t send_bit(input asp_core_t c);
        asp_core_t r;
        r = c;
        r.sdo = c.out_shift[15];
        r.out_shift = {c.out_shift[14:0], 1'b0};
        return r;
    endfunction

    // Deselect releases the output and leaves a byte where it stood, so a
    // later select resumes it; only a bare hunt is dropped.
    function automatic asp_core_t park(input asp_core_t c);
        asp_core_t r;
        r = c;
        r.sdo_oe = 1'b0;
        if (c.state == ASP_HUNT) begin
            r.state = ASP_IDLE;
        end
        return r;
    endfunction

    // Pin levels and edges arrive two system clocks after the pins move,
    // which the slowest legal link half period leaves ample room for.
    asp_pin_sync u_sync (
        .i_clk(I_MCLK),
        .i_rst(I_RST),
        .i_cs_n(I_CS_N),
        .i_sclk(I_SCLK),
        .i_din(I_DIN),
        .o_pins(pins)
    );

    // A transfer runs: select low, a hunt for the start bit, seven more bits
    // on detected rises, a one-cycle byte flag, then one result bit per
    // detected fall. A one seen during the data phase starts a new byte.
    always_comb begin
        st_next = st_reg;
        // Mode and result flag come from the converter side; stage 0 of each
        // chain is read by stage 1 only.
        st_next.mode_sync = {st_reg.mode_sync[0], I_INT_CLK_MODE};
        st_next.res_sync = {st_reg.res_sync[0], I_RESULT_VALID};
        int_timing = st_reg.mode_sync[1];
        result_seen = st_reg.res_sync[1];
        // The word is taken only while its synchronised flag says it is settled.
        if (result_seen) begin
            st_next.result_hold = I_RESULT;
        end
        st_next.core.cfg_valid = 1'b0;
        // The strobe ignores the select, so it is driven in every state.
        st_next.core.ready_strobe = int_timing & result_seen;
        if (pins.cs_n) begin
            st_next.core = park(st_next.core);
        end else begin
            st_next.core.sdo_oe = 1'b1;
            case (st_reg.core.state)
                ASP_IDLE: begin
                    st_next.core.state = ASP_HUNT;
                end
                ASP_HUNT: begin
                    if (start_bit_seen(pins)) begin
                        st_next.core = open_byte(st_next.core);
                    end
                end
                ASP_CFG: begin
                    if (pins.sclk_rise) begin
                        st_next.core = take_bit(st_next.core, pins.din, st_reg.result_hold);
                    end
                end
                ASP_DATA: begin
                    if (pins.sclk_fall) begin
                        st_next.core = send_bit(st_next.core);
                    end
                    if (start_bit_seen(pins)) begin
                        st_next.core = open_byte(st_next.core);
                    end
                end
                default: begin
                    st_next.core.state = ASP_IDLE;
                end
            endcase
        end
    end

    // Reset leaves the output released and the strobe low until the
    // synchronised mode and result flags say otherwise.
    always_ff @(posedge I_MCLK or posedge I_RST) begin
        if (I_RST) begin
            st_reg.core.state <= ASP_IDLE;
            st_reg.core.cfg_shift <= CFG_RESET;
            st_reg.core.cfg_count <= 3'h0;
            st_reg.core.out_shift <= RESULT_RESET;
            st_reg.core.sdo <= 1'b0;
            st_reg.core.sdo_oe <= 1'b0;
            st_reg.core.cfg_valid <= 1'b0;
            st_reg.core.cfg_word <= CFG_RESET;
            st_reg.core.ready_strobe <= 1'b0;
            st_reg.mode_sync <= 2'h0;
            st_reg.res_sync <= 2'h0;
            st_reg.result_hold <= RESULT_RESET;
        end else begin
            st_reg <= st_next;
        end
    end

    // Every output comes straight from a flip-flop.
    assign O_DOUT = st_reg.core.sdo;
    assign O_DOUT_OE = st_reg.core.sdo_oe;
    assign O_RESULT_READY_STROBE = st_reg.core.ready_strobe;
    assign O_CFG_VALID = st_reg.core.cfg_valid;
    assign O_CFG_BYTE = st_reg.core.cfg_word;
endmodule
`default_nettype wire

/* File: verilog/asp_pkg.sv */
package asp_pkg;

    // Position of the start bit inside the configuration byte.
    localparam int unsigned START_BIT_POS = 7;
    localparam int unsigned CFG_WIDTH = 8;
    localparam int unsigned RESULT_WIDTH = 16;
    localparam logic [7:0] CFG_RESET = 8'h00;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    typedef enum logic [1:0] {
        ASP_IDLE = 2'b00,
        ASP_HUNT = 2'b01,
        ASP_CFG = 2'b10,
        ASP_DATA = 2'b11
    } asp_state_t;

    // Synchronised pin levels with edge flags.
    typedef struct packed {
        logic cs_n;
        logic sclk_rise;
        logic sclk_fall;
        logic din;
    } asp_pins_t;

    typedef struct packed {
        logic [2:0] cs_n_sync;
        logic [2:0] sclk_sync;
        logic [1:0] din_sync;
    } asp_sync_t;

    typedef struct packed {
        asp_state_t state;
        logic [7:0] cfg_shift;
        logic [2:0] cfg_count;
        logic [15:0] out_shift;
        logic sdo;
        logic sdo_oe;
        logic cfg_valid;
        logic [7:0] cfg_word;
        logic ready_strobe;
    } asp_core_t;

endpackage

/* File: verilog/asp_pin_sync.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_pin_sync
    import asp_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst,
    input wire logic i_cs_n,
    input wire logic i_sclk,
    input wire logic i_din,
    output asp_pins_t o_pins
);
    asp_sync_t sync_reg;
    asp_sync_t sync_next;

    // Stage 0 feeds only stage 1; edges compare stages 1 and 2.
    always_comb begin
        sync_next.cs_n_sync = {sync_reg.cs_n_sync[1:0], i_cs_n};
        sync_next.sclk_sync = {sync_reg.sclk_sync[1:0], i_sclk};
        sync_next.din_sync = {sync_reg.din_sync[0], i_din};
    end

    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            sync_reg <= '{cs_n_sync: 3'h7, sclk_sync: 3'h0, din_sync: 2'h0};
        end else begin
            sync_reg <= sync_next;
        end
    end

    always_comb begin
        o_pins.cs_n = sync_reg.cs_n_sync[1];
        o_pins.sclk_rise = sync_reg.sclk_sync[1] & ~sync_reg.sclk_sync[2];
        o_pins.sclk_fall = ~sync_reg.sclk_sync[1] & sync_reg.sclk_sync[2];
        o_pins.din = sync_reg.din_sync[1];
    end
endmodule
`default_nettype wire

/* File: test/asp_serial_port_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_serial_port_asserts
    import asp_pkg::*;
(
    input wire logic I_MCLK,
    input wire logic I_RST,
    input wire logic I_CS_N,
    input wire logic I_SCLK,
    input wire logic I_INT_CLK_MODE,
    input wire logic I_RESULT_VALID,
    input wire logic O_DOUT,
    input wire logic O_DOUT_OE,
    input wire logic O_RESULT_READY_STROBE,
    input wire logic O_CFG_VALID,
    input wire logic [7:0] O_CFG_BYTE
);
    default clocking @(posedge I_MCLK); endclocking
    default disable iff (I_RST);
    AST_RISE: assert property (O_CFG_VALID |-> $past(I_SCLK, 2) && !$past(I_CS_N, 4))
        else $error("byte not on rise");
    AST_FALL: assert property ($changed(O_DOUT) && O_DOUT_OE |-> !$past(I_SCLK, 2))
        else $error("dout not on fall");
    AST_FROZEN: assert property (I_CS_N [*5] |-> !O_CFG_VALID)
        else $error("byte while idle");
    AST_RELEASE: assert property (I_CS_N [*4] |-> !O_DOUT_OE)
        else $error("dout driven");
    AST_DRIVE: assert property (!I_CS_N [*4] |-> O_DOUT_OE)
        else $error("dout not driven");
    AST_READY: assert property ((I_INT_CLK_MODE && I_RESULT_VALID) [*4] |-> O_RESULT_READY_STROBE)
        else $error("strobe low");
    AST_EXT: assert property (!I_INT_CLK_MODE [*4] |-> !O_RESULT_READY_STROBE)
        else $error("strobe high");
    AST_START: assert property (O_CFG_VALID |-> O_CFG_BYTE[7])
        else $error("no start bit");
endmodule
bind asp_serial_port asp_serial_port_asserts i_chk (.*);
`default_nettype wire

/* File: test/asp_host_model.sv */
`timescale 1ns/1ps
`default_nettype none
module asp_host_model (
    input wire logic i_dout,
    input wire logic i_dout_oe,
    output logic o_cs_n,
    output logic o_sclk,
    output logic o_din
);
    initial begin
        o_cs_n = 1'b1;
        o_sclk = 1'b0;
        o_din = 1'b0;
    end
    // One 125 ns clock: data set after the fall, line read at the rise.
    task automatic tick(input logic d, output logic q);
        o_din = d;
        #62.5 o_sclk = 1'b1;
        q = i_dout_oe ? i_dout : 1'bx;
        #62.5 o_sclk = 1'b0;
    endtask
    task automatic frame(input int lead, input logic [7:0] cfg, output logic [15:0] rd);
        logic q;
        o_cs_n = 1'b0;
        #100;
        for (int i = 0; i < lead + 8; i++) begin
            tick(i >= lead && cfg[7 + lead - i], q);
        end
        for (int i = 15; i >= 0; i--) begin
            tick(1'b0, q);
            rd[i] = q;
        end
        #100 o_cs_n = 1'b1;
        #100;
    endtask
    // Clock toggles with data held high and the device deselected.
    task automatic noise();
        logic q;
        for (int i = 0; i < 8; i++) begin
            tick(1'b1, q);
        end
    endtask
endmodule
`default_nettype wire

/* File: test/tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_mismatch++; \
    $display("FAIL %s exp %h got %h", n, e, a); end end
module tb;
    logic mclk = 1'b0;
    logic rst = 1'b1;
    logic mode = 1'b0;
    logic valid = 1'b0;
    logic [15:0] result = 16'h0000;
    logic [15:0] rd;
    wire logic cs_n, sclk, din, dout, dout_oe, strobe, cfg_valid;
    wire logic [7:0] cfg_byte;
    int n_mismatch = 0;
    int checks_done = 0;
    int cyc = 0;
    int n_cfg = 0;
    initial begin
        forever #5 mclk = ~mclk;
    end
    asp_serial_port i_asp_serial_port (.I_MCLK(mclk), .I_RST(rst), .I_CS_N(cs_n), .I_SCLK(sclk),
        .I_DIN(din), .I_INT_CLK_MODE(mode), .I_RESULT_VALID(valid), .I_RESULT(result),
        .O_DOUT(dout), .O_DOUT_OE(dout_oe), .O_RESULT_READY_STROBE(strobe),
        .O_CFG_VALID(cfg_valid), .O_CFG_BYTE(cfg_byte));
    asp_host_model i_asp_host_model (.i_dout(dout), .i_dout_oe(dout_oe), .o_cs_n(cs_n),
        .o_sclk(sclk), .o_din(din));
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        if (cfg_valid === 1'b1) begin
            n_cfg++;
        end
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            n_mismatch++;
            close_out();
        end
    end
    task automatic drive(input logic m, input logic v, input logic [15:0] r);
        @(posedge mclk);
        #1;
        mode = m;
        valid = v;
        result = r;
        repeat (6) @(posedge mclk);
        #1;
    endtask
    task automatic t_ext();
        drive(1'b0, 1'b1, 16'ha5c3);
        i_asp_host_model.frame(3, 8'h96, rd);
        `CHK("cfg", 8'h96, cfg_byte)
        `CHK("pulses", 1, n_cfg)
        `CHK("rd", 16'ha5c3, rd)
        `CHK("strobe", 1'b0, strobe)
        $display("t_ext done");
    endtask
    task automatic t_int();
        drive(1'b1, 1'b0, 16'h1234);
        `CHK("strobe", 1'b0, strobe)
        drive(1'b1, 1'b1, 16'h1234);
        `CHK("strobe", 1'b1, strobe)
        i_asp_host_model.frame(0, 8'hc1, rd);
        `CHK("rd", 16'h1234, rd)
        `CHK("pulses", 2, n_cfg)
        $display("t_int done");
    endtask
    task automatic t_desel();
        i_asp_host_model.noise();
        `CHK("cfg", 8'hc1, cfg_byte)
        `CHK("oe", 1'b0, dout_oe)
        `CHK("pulses", 2, n_cfg)
        $display("t_desel done");
    endtask
    initial begin
        repeat (6) @(posedge mclk);
        #1 rst = 1'b0;
        t_ext();
        t_int();
        t_desel();
        close_out();
    end
endmodule
`default_nettype wire
